// ---- verilog/rfpc_defines.svh ----
/*
  Named constants of the serial-to-RF packet controller: frame layout,
  flow-control codes and thresholds, CRC parameters, default bit timing.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef RFPC_DEFINES_SVH
`define RFPC_DEFINES_SVH

`define RFPC_CLK_HZ 10000000
`define RFPC_DEF_BAUD 9600
`define RFPC_DEF_BAUD_DIV (`RFPC_CLK_HZ / `RFPC_DEF_BAUD)
`define RFPC_MAX_PAYLOAD 7'h40
`define RFPC_HDR_LAST 3'h4
`define RFPC_CTS_DEF_THR 65
`define RFPC_CTS_REASSERT 34
`define RFPC_XON 8'h11
`define RFPC_XOFF 8'h13
`define RFPC_RTS_FLOW 2'h2
`define RFPC_CRC_POLY 16'h1021
`define RFPC_CRC_INIT 16'hFFFF
`define RFPC_CRC_RESIDUE 16'h0000
`define RFPC_CRC_BYTES 2

`endif

// ---- verilog/rfpc_pkg.sv ----
/*
  Types of the serial-to-RF packet controller: operating-mode states and
  the host UART engine states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rfpc_pkg;

  typedef enum logic [9:0] {
    RFPC_IDLE    = 10'h001,
    RFPC_TX_INIT = 10'h002,
    RFPC_TX_HDR  = 10'h004,
    RFPC_TX_DATA = 10'h008,
    RFPC_TX_CRC  = 10'h010,
    RFPC_RX_HDR  = 10'h020,
    RFPC_RX_DATA = 10'h040,
    RFPC_RX_SKIP = 10'h080,
    RFPC_SLEEP   = 10'h100,
    RFPC_CMD     = 10'h200
  } rfpc_state_e;

  typedef enum logic [3:0] {
    RFPC_U_IDLE  = 4'h1,
    RFPC_U_START = 4'h2,
    RFPC_U_DATA  = 4'h4,
    RFPC_U_STOP  = 4'h8
  } rfpc_ustate_e;

endpackage : rfpc_pkg

// ---- verilog/rfpc_uart.sv ----
/*
  Host-side 8-N-1 UART engine: one receiver, one transmitter, bit time
  set in clock cycles by an input.
  Assumes rxd is synchronous to sys_clk and bit_div is at least 2.
*/
`include "rfpc_defines.svh"

module rfpc_uart (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [15:0] bit_div,
  input wire logic rxd,
  input wire logic tx_start,
  input wire logic [7:0] tx_data,
  output logic txd,
  output logic tx_busy,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_ferr
);
  import rfpc_pkg::*;

  typedef struct packed {
    rfpc_ustate_e rx_st;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_ferr;
    rfpc_ustate_e tx_st;
    logic [15:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic txd;
    logic busy;
  } rfpc_uart_s;

  rfpc_uart_s u_ff;
  rfpc_uart_s nxt_u;

  always_comb begin
    nxt_u = u_ff;
    nxt_u.rx_valid = 1'b0;
    nxt_u.rx_ferr = 1'b0;
    // Receiver: sample mid-bit, start bit checked again half a bit in
    case (u_ff.rx_st)
      RFPC_U_IDLE: begin
        if (!rxd) begin
          nxt_u.rx_st = RFPC_U_START;
          nxt_u.rx_cnt = bit_div >> 1;
        end
      end
      RFPC_U_START: begin
        if (u_ff.rx_cnt == 16'h0000) begin
          nxt_u.rx_st = rxd ? RFPC_U_IDLE : RFPC_U_DATA;
          nxt_u.rx_cnt = bit_div - 16'h0001;
          nxt_u.rx_bit = 3'h0;
        end else begin
          nxt_u.rx_cnt = u_ff.rx_cnt - 16'h0001;
        end
      end
      RFPC_U_DATA: begin
        if (u_ff.rx_cnt == 16'h0000) begin
          nxt_u.rx_sh = {rxd, u_ff.rx_sh[7:1]};
          nxt_u.rx_cnt = bit_div - 16'h0001;
          nxt_u.rx_bit = u_ff.rx_bit + 3'h1;
          if (u_ff.rx_bit == 3'h7) begin
            nxt_u.rx_st = RFPC_U_STOP;
          end
        end else begin
          nxt_u.rx_cnt = u_ff.rx_cnt - 16'h0001;
        end
      end
      RFPC_U_STOP: begin
        if (u_ff.rx_cnt == 16'h0000) begin
          nxt_u.rx_st = RFPC_U_IDLE;
          nxt_u.rx_valid = rxd;
          nxt_u.rx_ferr = !rxd;
          nxt_u.rx_data = u_ff.rx_sh;
        end else begin
          nxt_u.rx_cnt = u_ff.rx_cnt - 16'h0001;
        end
      end
      default: begin
        nxt_u.rx_st = RFPC_U_IDLE;
      end
    endcase
    // Transmitter
    case (u_ff.tx_st)
      RFPC_U_IDLE: begin
        nxt_u.txd = 1'b1;
        if (tx_start) begin
          nxt_u.tx_st = RFPC_U_START;
          nxt_u.tx_sh = tx_data;
          nxt_u.txd = 1'b0;
          nxt_u.tx_cnt = bit_div - 16'h0001;
        end
      end
      RFPC_U_START: begin
        if (u_ff.tx_cnt == 16'h0000) begin
          nxt_u.tx_st = RFPC_U_DATA;
          nxt_u.txd = u_ff.tx_sh[0];
          nxt_u.tx_sh = {1'b0, u_ff.tx_sh[7:1]};
          nxt_u.tx_bit = 3'h0;
          nxt_u.tx_cnt = bit_div - 16'h0001;
        end else begin
          nxt_u.tx_cnt = u_ff.tx_cnt - 16'h0001;
        end
      end
      RFPC_U_DATA: begin
        if (u_ff.tx_cnt == 16'h0000) begin
          nxt_u.tx_cnt = bit_div - 16'h0001;
          if (u_ff.tx_bit == 3'h7) begin
            nxt_u.tx_st = RFPC_U_STOP;
            nxt_u.txd = 1'b1;
          end else begin
            nxt_u.txd = u_ff.tx_sh[0];
            nxt_u.tx_sh = {1'b0, u_ff.tx_sh[7:1]};
            nxt_u.tx_bit = u_ff.tx_bit + 3'h1;
          end
        end else begin
          nxt_u.tx_cnt = u_ff.tx_cnt - 16'h0001;
        end
      end
      RFPC_U_STOP: begin
        if (u_ff.tx_cnt == 16'h0000) begin
          nxt_u.tx_st = RFPC_U_IDLE;
        end else begin
          nxt_u.tx_cnt = u_ff.tx_cnt - 16'h0001;
        end
      end
      default: begin
        nxt_u.tx_st = RFPC_U_IDLE;
      end
    endcase
    nxt_u.busy = (nxt_u.tx_st != RFPC_U_IDLE);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      u_ff <= '0;
      u_ff.rx_st <= RFPC_U_IDLE;
      u_ff.tx_st <= RFPC_U_IDLE;
      u_ff.txd <= 1'b1;
    end else begin
      u_ff <= nxt_u;
    end
  end

  assign txd = u_ff.txd;
  assign tx_busy = u_ff.busy;
  assign rx_valid = u_ff.rx_valid;
  assign rx_data = u_ff.rx_data;
  assign rx_ferr = u_ff.rx_ferr;

endmodule : rfpc_uart

// ---- verilog/rfpc_ctrl.sv ----
/*
  Serial-to-RF packet controller: inbound and outbound byte buffers, host
  flow control, RF packet framing with initializer, header and CRC, and
  the idle / transmit / receive / sleep / command sequencer.
  Assumes an RF byte engine on the rf_* ports and all inputs synchronous
  to sys_clk; rf_carrier rises before the first byte of a reception.
*/
// What this block does
// - Host characters are 8-N-1, LSB first
// - Store host bytes until sent over RF
// - Start RF at threshold unless receiving
// - Deassert CTS near full, threshold set
// - Reassert CTS after 34 bytes freed
// - Optional XON/XOFF pausing both directions
// - RF payload to outbound buffer; overflow discarded
// - RTS deasserted stops buffered data output when setting 2; XON/XOFF codes still go
// - Idle exits to transmit, receive, sleep, command
// - Buffered bytes reaching threshold start transmit attempt
// - Initializer only before first packet of stream
// - Packets up to 64 bytes until empty
// - Pending data gives next packet, no initializer
// - Initializer with channel on each new sequence
// - Wake-up initializer longer than remote sleep; length is init_len
// - Discard packets failing identifier, channel, address
// - Append 16-bit CRC to each packet
// - Forward received packet only on CRC match
// - Detected RF data moves idle to receive
// - Receive ends on loss or error, back to idle, which transmits at threshold
// - Activity pin low in transmit and sleep, high otherwise
`include "rfpc_defines.svh"

module rfpc_ctrl #(
  parameter int IB_DEPTH = 1024,
  parameter int OB_DEPTH = 256,
  localparam int IBW = $clog2(IB_DEPTH),
  localparam int OBW = $clog2(OB_DEPTH)
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic serial_in,
  output logic serial_out,
  output logic cts_b,
  input wire logic rts_b,
  output logic tx_pwr,
  input wire logic [15:0] serial_rate_setting,
  input wire logic [IBW:0] packetization_threshold,
  input wire logic [IBW:0] flow_threshold_setting,
  input wire logic cts_enable,
  input wire logic software_flow_setting,
  input wire logic [1:0] outbound_flow_setting,
  input wire logic [15:0] network_identifier,
  input wire logic [7:0] hop_channel,
  input wire logic [15:0] dest_addr,
  input wire logic [15:0] own_addr,
  input wire logic [7:0] init_len,
  input wire logic sleep_req,
  input wire logic cmd_req,
  input wire logic rf_carrier,
  input wire logic rf_rx_valid,
  input wire logic [7:0] rf_rx_data,
  input wire logic rf_rx_last,
  input wire logic rf_rx_error,
  output logic rf_tx_valid,
  output logic [7:0] rf_tx_data,
  output logic rf_tx_init,
  output logic rf_tx_first,
  output logic rf_tx_last,
  input wire logic rf_tx_ready,
  output rfpc_pkg::rfpc_state_e op_mode,
  output logic rx_pkt_good,
  output logic rx_pkt_drop,
  output logic ib_overflow
);
  import rfpc_pkg::*;

  typedef struct packed {
    rfpc_state_e st;
    logic [IBW:0] ib_wr;
    logic [IBW:0] ib_rd;
    logic [OBW:0] ob_wr;
    logic [OBW:0] ob_tmp;
    logic [OBW:0] ob_rd;
    logic [7:0] idx;
    logic [6:0] pkt;
    logic [15:0] crc;
    logic hdr_ok;
    logic ob_drop;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_init;
    logic tx_first;
    logic tx_last;
    logic tx_is_data;
    logic near_full;
    logic cts_b;
    logic host_paused;
    logic xoff_sent;
    logic flow_req;
    logic [7:0] flow_code;
    logic ut_start;
    logic [7:0] ut_data;
    logic pwr;
    logic good_p;
    logic drop_p;
    logic ovf_p;
  } rfpc_ctrl_s;

  localparam logic [IBW:0] IB_FULL = (IBW + 1)'(IB_DEPTH);
  localparam logic [OBW:0] OB_FULL = (OBW + 1)'(OB_DEPTH);

  rfpc_ctrl_s r_ff;
  rfpc_ctrl_s nxt_r;
  logic [7:0] ib_mem [IB_DEPTH];
  logic [7:0] ob_mem [OB_DEPTH];
  logic ib_we;
  logic ob_we;
  logic ut_busy;
  logic ut_rx_valid;
  logic [7:0] ut_rx_data;
  logic [IBW:0] ib_count;
  logic [IBW:0] ib_free;
  logic [OBW:0] ob_count;
  logic [OBW:0] ob_used;

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      x = x[15] ? ((x << 1) ^ `RFPC_CRC_POLY) : (x << 1);
    end
    return x;
  endfunction : crc_byte

  // Header order: identifier, channel, address, each MSB first
  function automatic logic [7:0] hdr_byte(input logic [2:0] i,
                                          input logic [15:0] nid,
                                          input logic [7:0] ch,
                                          input logic [15:0] adr);
    case (i)
      3'h0: return nid[15:8];
      3'h1: return nid[7:0];
      3'h2: return ch;
      3'h3: return adr[15:8];
      default: return adr[7:0];
    endcase
  endfunction : hdr_byte

  function automatic logic is_tx(input rfpc_state_e s);
    return (s == RFPC_TX_INIT) || (s == RFPC_TX_HDR) ||
           (s == RFPC_TX_DATA) || (s == RFPC_TX_CRC);
  endfunction : is_tx

  rfpc_uart u_uart (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .bit_div(serial_rate_setting),
    .rxd(serial_in),
    .tx_start(r_ff.ut_start),
    .tx_data(r_ff.ut_data),
    .txd(serial_out),
    .tx_busy(ut_busy),
    .rx_valid(ut_rx_valid),
    .rx_data(ut_rx_data),
    .rx_ferr()
  );

  assign ib_count = r_ff.ib_wr - r_ff.ib_rd;
  assign ib_free = IB_FULL - ib_count;
  assign ob_count = r_ff.ob_wr - r_ff.ob_rd;
  assign ob_used = r_ff.ob_tmp - r_ff.ob_rd;

  always_comb begin
    logic [7:0] b;
    logic [15:0] c;
    logic [OBW:0] tmp;
    logic rx_restart;
    logic load;
    b = 8'h00;
    c = r_ff.crc;
    tmp = r_ff.ob_tmp;
    rx_restart = 1'b0;
    load = !r_ff.tx_valid;
    nxt_r = r_ff;
    ib_we = 1'b0;
    ob_we = 1'b0;
    nxt_r.ut_start = 1'b0;
    nxt_r.good_p = 1'b0;
    nxt_r.drop_p = 1'b0;
    nxt_r.ovf_p = 1'b0;

    // Host input; flow codes are consumed only when software flow is on
    if (ut_rx_valid) begin
      if (software_flow_setting && ut_rx_data == `RFPC_XOFF) begin
        nxt_r.host_paused = 1'b1;
      end else if (software_flow_setting && ut_rx_data == `RFPC_XON) begin
        nxt_r.host_paused = 1'b0;
      end else if (ib_count != IB_FULL) begin
        ib_we = 1'b1;
        nxt_r.ib_wr = r_ff.ib_wr + 1'b1;
      end else begin
        nxt_r.ovf_p = 1'b1;
      end
    end

    // Hysteresis keeps CTS from chattering at the threshold
    if (!r_ff.near_full && ib_free <= flow_threshold_setting) begin
      nxt_r.near_full = 1'b1;
    end else if (r_ff.near_full && {1'b0, ib_free} >=
                 {1'b0, flow_threshold_setting} +
                 (IBW + 2)'(`RFPC_CTS_REASSERT)) begin
      nxt_r.near_full = 1'b0;
    end
    if (software_flow_setting && r_ff.near_full != r_ff.xoff_sent) begin
      nxt_r.flow_req = 1'b1;
      nxt_r.flow_code = r_ff.near_full ? `RFPC_XOFF : `RFPC_XON;
      nxt_r.xoff_sent = r_ff.near_full;
    end

    // Host output: flow codes go ahead of buffered data
    if (!ut_busy && !r_ff.ut_start) begin
      if (r_ff.flow_req) begin
        nxt_r.ut_start = 1'b1;
        nxt_r.ut_data = r_ff.flow_code;
        nxt_r.flow_req = 1'b0;
      end else if (ob_count != '0 &&
                   !(outbound_flow_setting == `RFPC_RTS_FLOW && rts_b) &&
                   !(software_flow_setting && r_ff.host_paused)) begin
        nxt_r.ut_start = 1'b1;
        nxt_r.ut_data = ob_mem[r_ff.ob_rd[OBW-1:0]];
        nxt_r.ob_rd = r_ff.ob_rd + 1'b1;
      end
    end

    // A byte leaves the inbound buffer only once the RF side took it
    if (r_ff.tx_valid && rf_tx_ready) begin
      nxt_r.tx_valid = 1'b0;
      if (r_ff.tx_is_data) begin
        nxt_r.ib_rd = r_ff.ib_rd + 1'b1;
      end
    end

    case (r_ff.st)
      RFPC_IDLE: begin
        if (rf_carrier) begin
          nxt_r.st = RFPC_RX_HDR;
          rx_restart = 1'b1;
        end else if (ib_count != '0 &&
                     ib_count >= packetization_threshold) begin
          nxt_r.st = RFPC_TX_INIT;
          nxt_r.idx = 8'h00;
        end else if (sleep_req) begin
          nxt_r.st = RFPC_SLEEP;
        end else if (cmd_req) begin
          nxt_r.st = RFPC_CMD;
        end
      end
      RFPC_TX_INIT: begin
        if (load) begin
          nxt_r.tx_valid = 1'b1;
          nxt_r.tx_data = hop_channel;
          nxt_r.tx_init = 1'b1;
          nxt_r.tx_first = 1'b0;
          nxt_r.tx_last = 1'b0;
          nxt_r.tx_is_data = 1'b0;
          nxt_r.idx = r_ff.idx + 8'h01;
          // Length is software's to set against remote sleep time
          if (r_ff.idx + 8'h01 >= init_len) begin
            nxt_r.st = RFPC_TX_HDR;
            nxt_r.idx = 8'h00;
            nxt_r.crc = `RFPC_CRC_INIT;
          end
        end
      end
      RFPC_TX_HDR: begin
        if (load) begin
          b = hdr_byte(r_ff.idx[2:0], network_identifier, hop_channel,
                       dest_addr);
          nxt_r.tx_valid = 1'b1;
          nxt_r.tx_data = b;
          nxt_r.tx_init = 1'b0;
          nxt_r.tx_first = (r_ff.idx == 8'h00);
          nxt_r.tx_last = 1'b0;
          nxt_r.tx_is_data = 1'b0;
          nxt_r.crc = crc_byte(r_ff.crc, b);
          nxt_r.idx = r_ff.idx + 8'h01;
          if (r_ff.idx[2:0] == `RFPC_HDR_LAST) begin
            nxt_r.st = RFPC_TX_DATA;
            nxt_r.pkt = 7'h00;
          end
        end
      end
      RFPC_TX_DATA: begin
        if (load) begin
          if (ib_count == '0 || r_ff.pkt == `RFPC_MAX_PAYLOAD) begin
            nxt_r.st = RFPC_TX_CRC;
            nxt_r.idx = 8'h00;
          end else begin
            b = ib_mem[r_ff.ib_rd[IBW-1:0]];
            nxt_r.tx_valid = 1'b1;
            nxt_r.tx_data = b;
            nxt_r.tx_first = 1'b0;
            nxt_r.tx_is_data = 1'b1;
            nxt_r.crc = crc_byte(r_ff.crc, b);
            nxt_r.pkt = r_ff.pkt + 7'h01;
          end
        end
      end
      RFPC_TX_CRC: begin
        if (load) begin
          nxt_r.tx_valid = 1'b1;
          nxt_r.tx_is_data = 1'b0;
          nxt_r.tx_data = (r_ff.idx == 8'h00) ? r_ff.crc[15:8] :
                          r_ff.crc[7:0];
          nxt_r.tx_last = (r_ff.idx == 8'h01);
          nxt_r.idx = r_ff.idx + 8'h01;
          if (r_ff.idx == 8'h01) begin
            if (ib_count != '0) begin
              nxt_r.st = RFPC_TX_HDR;
              nxt_r.idx = 8'h00;
              nxt_r.crc = `RFPC_CRC_INIT;
            end else begin
              nxt_r.st = RFPC_IDLE;
            end
          end
        end
      end
      RFPC_RX_HDR: begin
        if (rf_rx_error || !rf_carrier) begin
          nxt_r.st = RFPC_IDLE;
          nxt_r.drop_p = (r_ff.idx != 8'h00);
        end else if (rf_rx_valid) begin
          nxt_r.crc = crc_byte(r_ff.crc, rf_rx_data);
          if (rf_rx_data != hdr_byte(r_ff.idx[2:0], network_identifier,
                                     hop_channel, own_addr)) begin
            nxt_r.hdr_ok = 1'b0;
          end
          nxt_r.idx = r_ff.idx + 8'h01;
          if (rf_rx_last) begin
            nxt_r.drop_p = 1'b1;
            rx_restart = 1'b1;
          end else if (r_ff.idx[2:0] == `RFPC_HDR_LAST) begin
            nxt_r.st = (nxt_r.hdr_ok) ? RFPC_RX_DATA : RFPC_RX_SKIP;
          end
        end
      end
      RFPC_RX_DATA: begin
        if (rf_rx_error || !rf_carrier) begin
          nxt_r.st = RFPC_IDLE;
          nxt_r.drop_p = 1'b1;
        end else if (rf_rx_valid) begin
          c = crc_byte(r_ff.crc, rf_rx_data);
          nxt_r.crc = c;
          if (ob_used != OB_FULL) begin
            ob_we = 1'b1;
            tmp = r_ff.ob_tmp + 1'b1;
            nxt_r.ob_tmp = tmp;
          end else begin
            nxt_r.ob_drop = 1'b1;
          end
          if (rf_rx_last) begin
            // The CRC trailer was stored too; it is cut off at commit
            if (c == `RFPC_CRC_RESIDUE && !nxt_r.ob_drop &&
                tmp - r_ff.ob_wr >= (OBW + 1)'(`RFPC_CRC_BYTES)) begin
              nxt_r.ob_wr = tmp - (OBW + 1)'(`RFPC_CRC_BYTES);
              nxt_r.good_p = 1'b1;
            end else begin
              nxt_r.drop_p = 1'b1;
            end
            nxt_r.st = RFPC_RX_HDR;
            rx_restart = 1'b1;
          end
        end
      end
      RFPC_RX_SKIP: begin
        if (rf_rx_error || !rf_carrier) begin
          nxt_r.st = RFPC_IDLE;
          nxt_r.drop_p = 1'b1;
        end else if (rf_rx_valid && rf_rx_last) begin
          nxt_r.st = RFPC_RX_HDR;
          nxt_r.drop_p = 1'b1;
          rx_restart = 1'b1;
        end
      end
      RFPC_SLEEP: begin
        if (!sleep_req) begin
          nxt_r.st = RFPC_IDLE;
        end
      end
      RFPC_CMD: begin
        if (!cmd_req) begin
          nxt_r.st = RFPC_IDLE;
        end
      end
      default: begin
        nxt_r.st = RFPC_IDLE;
      end
    endcase

    if (rx_restart) begin
      nxt_r.idx = 8'h00;
      nxt_r.crc = `RFPC_CRC_INIT;
      nxt_r.hdr_ok = 1'b1;
      nxt_r.ob_drop = 1'b0;
      nxt_r.ob_tmp = nxt_r.ob_wr;
    end
    nxt_r.cts_b = (cts_enable && nxt_r.near_full) ||
                  (nxt_r.st == RFPC_SLEEP);
    nxt_r.pwr = !is_tx(nxt_r.st) && (nxt_r.st != RFPC_SLEEP);
  end

  always_ff @(posedge sys_clk) begin
    if (ib_we) begin
      ib_mem[r_ff.ib_wr[IBW-1:0]] <= ut_rx_data;
    end
    if (ob_we) begin
      ob_mem[r_ff.ob_tmp[OBW-1:0]] <= rf_rx_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      r_ff <= '0;
      r_ff.st <= RFPC_IDLE;
      r_ff.crc <= `RFPC_CRC_INIT;
      r_ff.pwr <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign cts_b = r_ff.cts_b;
  assign tx_pwr = r_ff.pwr;
  assign rf_tx_valid = r_ff.tx_valid;
  assign rf_tx_data = r_ff.tx_data;
  assign rf_tx_init = r_ff.tx_init;
  assign rf_tx_first = r_ff.tx_first;
  assign rf_tx_last = r_ff.tx_last;
  assign op_mode = r_ff.st;
  assign rx_pkt_good = r_ff.good_p;
  assign rx_pkt_drop = r_ff.drop_p;
  assign ib_overflow = r_ff.ovf_p;

endmodule : rfpc_ctrl

// ---- bench/rfpc_ctrl_properties.sv ----
/*
  Port checker of rfpc_ctrl, bound after the module.
  Assumes one clock, a bit time of 4 cycles and tied sleep/command requests.
*/
module rfpc_ctrl_properties (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic serial_out,
  input wire logic rts_b,
  input wire logic tx_pwr,
  input wire logic [1:0] outbound_flow_setting,
  input wire logic [7:0] hop_channel,
  input wire logic rf_carrier,
  input wire logic rf_rx_valid,
  input wire logic rf_rx_last,
  input wire logic rf_tx_valid,
  input wire logic [7:0] rf_tx_data,
  input wire logic rf_tx_init,
  input wire logic rf_tx_ready,
  input wire rfpc_pkg::rfpc_state_e op_mode,
  input wire logic rx_pkt_good,
  input wire logic rx_pkt_drop
);
  timeunit 1ns;
  timeprecision 1ns;
  import rfpc_pkg::*;
  logic in_tx;
  logic in_rx;
  logic [7:0] gate_ff;
  assign in_tx = op_mode inside {RFPC_TX_INIT, RFPC_TX_HDR, RFPC_TX_DATA,
                                 RFPC_TX_CRC};
  assign in_rx = op_mode inside {RFPC_RX_HDR, RFPC_RX_DATA, RFPC_RX_SKIP};
  // A byte already on the wire may finish, so allow one frame first
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !(outbound_flow_setting == 2'h2 && rts_b))
      gate_ff <= 8'h00;
    else if (gate_ff != 8'hFF)
      gate_ff <= gate_ff + 8'h01;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_hold; rf_tx_valid && !rf_tx_ready |=> rf_tx_valid && $stable(rf_tx_data); endproperty
  a_hold: assert property (p_hold) else $error("rf byte changed");
  property p_gap; rf_tx_valid && rf_tx_ready |=> !rf_tx_valid; endproperty
  a_gap: assert property (p_gap) else $error("no idle cycle");
  property p_init; rf_tx_valid && rf_tx_init |-> rf_tx_data == hop_channel; endproperty
  a_init: assert property (p_init) else $error("bad init byte");
  property p_rx_in; op_mode == RFPC_IDLE && rf_carrier |=> op_mode == RFPC_RX_HDR; endproperty
  a_rx_in: assert property (p_rx_in) else $error("no receive");
  property p_rx_out; in_rx && !rf_carrier |-> ##[1:2] op_mode == RFPC_IDLE; endproperty
  a_rx_out: assert property (p_rx_out) else $error("stuck in rx");
  property p_good; rx_pkt_good |-> $past(rf_rx_valid && rf_rx_last); endproperty
  a_good: assert property (p_good) else $error("stray good");
  property p_pwr; in_tx && $past(in_tx) |-> !tx_pwr; endproperty
  a_pwr: assert property (p_pwr) else $error("pwr high in tx");
  property p_rts; gate_ff > 8'h3C |-> serial_out; endproperty
  a_rts: assert property (p_rts) else $error("sent under rts");
  property p_mode; $onehot(op_mode); endproperty
  a_mode: assert property (p_mode) else $error("mode not onehot");
  c_good: cover property (rx_pkt_good);
  c_drop: cover property (rx_pkt_drop);
  c_init: cover property (rf_tx_valid && rf_tx_ready && rf_tx_init);
endmodule : rfpc_ctrl_properties

bind rfpc_ctrl rfpc_ctrl_properties u_prop (.*);

// ---- bench/rfpc_host_model.sv ----
/*
  Host UART model: sends 8-N-1 bytes honouring CTS, collects output bytes.
  Assumes the bench calls send just after a rising clock edge.
*/
module rfpc_host_model #(
  parameter int BIT = 4
) (
  input wire logic sys_clk,
  input wire logic cts_b,
  input wire logic serial_out,
  output logic serial_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];
  initial serial_in = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    while (cts_b !== 1'b0) @(posedge sys_clk) #1;
    for (int i = 0; i < 10; i++) begin
      serial_in = f[i];
      repeat (BIT) @(posedge sys_clk);
      #1;
    end
  endtask : send
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge serial_out);
      repeat (BIT / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge sys_clk);
        b[i] = serial_out;
      end
      repeat (BIT) @(posedge sys_clk);
      if (serial_out === 1'b1) rx_q.push_back(b);
    end
  end
endmodule : rfpc_host_model

// ---- bench/rfpc_ctrl_tb_top.sv ----
/*
  Bench of rfpc_ctrl: host model on the serial pins, RF engine in here.
  Assumes default buffer depths and a bit time of 4 cycles.
*/
`include "rfpc_defines.svh"
module rfpc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rfpc_pkg::*;
  localparam logic [15:0] NID = 16'h5A3C;
  localparam logic [7:0] CH = 8'h07;
  localparam logic [15:0] ADR = 16'h0042;
  logic sys_clk, rst_b, serial_in, serial_out, cts_b, tx_pwr;
  logic rts_b = 1'b0, rf_carrier = 1'b0, rf_rx_valid = 1'b0;
  logic rf_rx_last = 1'b0, rf_rx_error = 1'b0, rf_tx_ready = 1'b0;
  logic [7:0] rf_rx_data = 8'h00, hop_channel = CH, init_len = 8'h02;
  logic [15:0] serial_rate_setting = 16'h0004, network_identifier = NID;
  logic [15:0] dest_addr = ADR, own_addr = ADR;
  logic [10:0] packetization_threshold = 11'h003;
  logic [10:0] flow_threshold_setting = 11'h041;
  logic cts_enable = 1'b1, software_flow_setting = 1'b0;
  logic sleep_req = 1'b0, cmd_req = 1'b0;
  logic [1:0] outbound_flow_setting = 2'h0;
  logic rf_tx_valid, rf_tx_init, rf_tx_first, rf_tx_last;
  logic rx_pkt_good, rx_pkt_drop, ib_overflow;
  logic [7:0] rf_tx_data;
  rfpc_state_e op_mode;
  logic [7:0] txq[$];
  logic [2:0] flq[$];
  int err_total = 0, tests_run = 0, n_good = 0, n_drop = 0, cyc = 0;
  int n_ovf = 0;
  rfpc_ctrl u_dut (.*);
  rfpc_host_model #(.BIT(4)) u_host (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    if (err_total == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = `RFPC_CRC_INIT;
    foreach (q[i]) begin
      c ^= {q[i], 8'h00};
      repeat (8) c = c[15] ? (c << 1) ^ `RFPC_CRC_POLY : c << 1;
    end
    return c;
  endfunction : crc16
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Engine accepts on every other cycle so the controller sees stalls
  always @(posedge sys_clk) begin
    if (rf_tx_valid && rf_tx_ready) begin
      txq.push_back(rf_tx_data);
      flq.push_back({rf_tx_init, rf_tx_first, rf_tx_last});
    end
    n_good += rx_pkt_good;
    n_drop += rx_pkt_drop;
    n_ovf += ib_overflow;
    rf_tx_ready <= #1 ~rf_tx_ready;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic t_tx;
    logic [7:0] h[$];
    logic [15:0] c;
    rf_carrier = 1'b1;
    for (int i = 0; i < 3; i++) u_host.send(8'hA0 + i);
    repeat (20) @(posedge sys_clk);
    chk(txq.size(), 0);
    chk(n_ovf, 0);
    #1 rf_carrier = 1'b0;
    repeat (400) @(posedge sys_clk);
    h = {NID[15:8], NID[7:0], CH, ADR[15:8], ADR[7:0], 8'hA0, 8'hA1, 8'hA2};
    c = crc16(h);
    h = {CH, CH, h, c[15:8], c[7:0]};
    chk(txq.size(), h.size());
    foreach (h[i]) chk(txq[i], h[i]);
    chk(flq[1], 3'h4);
    chk(flq[2], 3'h2);
    chk(flq[11], 3'h1);
    chk(op_mode, RFPC_IDLE);
    #1;
  endtask : t_tx
  task automatic rf_pkt(input logic [7:0] p[$], input logic bad);
    logic [15:0] c;
    c = crc16(p) ^ {15'h0, bad};
    p = {p, c[15:8], c[7:0]};
    n_good = 0;
    n_drop = 0;
    rf_carrier = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    foreach (p[i]) begin
      rf_rx_valid = 1'b1;
      rf_rx_data = p[i];
      rf_rx_last = (i == p.size() - 1);
      @(posedge sys_clk);
      #1 rf_rx_valid = 1'b0;
      @(posedge sys_clk);
      #1;
    end
    repeat (3) @(posedge sys_clk);
    #1 rf_carrier = 1'b0;
    // Let the carrier loss be seen before the next packet raises it
    @(posedge sys_clk);
    #1;
  endtask : rf_pkt
  task automatic t_rx;
    logic [7:0] h[$];
    h = {NID[15:8], NID[7:0], CH, ADR[15:8], ADR[7:0]};
    rf_pkt({h, 8'h3C, 8'h00}, 1'b1);
    chk(n_drop, 1);
    rf_pkt({h[0:2], 8'h00, 8'h43, 8'h3C}, 1'b0);
    chk(n_drop, 1);
    outbound_flow_setting = 2'h2;
    rts_b = 1'b1;
    rf_pkt({h, 8'h3C, 8'h00}, 1'b0);
    chk(n_good, 1);
    repeat (200) @(posedge sys_clk);
    chk(u_host.rx_q.size(), 0);
    #1 rts_b = 1'b0;
    repeat (200) @(posedge sys_clk);
    chk(u_host.rx_q.size(), 2);
    chk(u_host.rx_q[0], 8'h3C);
    chk(u_host.rx_q[1], 8'h00);
  endtask : t_rx
  task automatic t_sleep;
    #1 sleep_req = 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(op_mode, RFPC_SLEEP);
    chk(cts_b, 1'b1);
    chk(tx_pwr, 1'b0);
    #1 sleep_req = 1'b0;
    cmd_req = 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(op_mode, RFPC_CMD);
    chk(tx_pwr, 1'b1);
    #1 cmd_req = 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : t_sleep
  initial begin
    rst_b = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    @(posedge sys_clk);
    #1;
    t_tx();
    t_rx();
    t_sleep();
    end_sim();
  end
endmodule : rfpc_ctrl_tb_top
